// ### core/timed_io_ports.sv
// Purpose: Timed unidirectional I/O ports with six clock blocks
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Pins and strobes pass two flip-flops before use
`timescale 1ns/1ps
`include "tio_params.svh"
module timed_io_ports #(
   parameter int NUM_PORTS               = 5,
   parameter int PORT_WIDTH [NUM_PORTS]  = '{1, 4, 8, 16, 32},
   parameter int PORT_BASE  [NUM_PORTS]  = '{0, 4, 0, 0, 0},
   parameter int LINK_BASE               = 8,
   parameter int LINK_WIDTH              = 4
) (
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      resetn,
   // Register port
   input  wire tio_pkg::bus_req_type      bus_req,
   output logic [31:0]                    rd_data,
   // Pins
   input  wire logic [`PIN_COUNT-1:0]     pin_in,
   output logic [`PIN_COUNT-1:0]          pin_out,
   output logic [`PIN_COUNT-1:0]          pin_oe,
   // Strobes
   input  wire logic [NUM_PORTS-1:0]      strobe_in,
   output logic [NUM_PORTS-1:0]           output_qualify_strobe,
   // Events
   output logic [NUM_PORTS-1:0]           ready_event
);
   import tio_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic [`PIN_COUNT-1:0] pin_meta_reg;
   logic [`PIN_COUNT-1:0] pin_sync_reg;
   logic [NUM_PORTS-1:0]  strobe_meta_reg;
   logic [NUM_PORTS-1:0]  strobe_sync_reg;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pin_meta_reg    <= '0;
         pin_sync_reg    <= '0;
         strobe_meta_reg <= '0;
         strobe_sync_reg <= '0;
      end else begin
         pin_meta_reg    <= pin_in;
         pin_sync_reg    <= pin_meta_reg;
         strobe_meta_reg <= strobe_in;
         strobe_sync_reg <= strobe_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   wire [2:0]  win_sel;
   wire [4:0]  reg_sel;
   wire [2:0]  cb_idx;
   wire        port_hit;
   wire        cb_hit;
   wire        link_hit;

   assign win_sel  = bus_req.addr[7:5];
   assign reg_sel  = bus_req.addr[4:0];
   assign cb_idx   = bus_req.addr[4:2];
   assign port_hit = 32'(win_sel) < NUM_PORTS;
   assign cb_hit   = ((bus_req.addr & `CB_WIN_MASK) == `CB_BASE) &&
                     (bus_req.addr[1:0] == 2'h0) && (cb_idx < 3'(`NUM_CB));
   assign link_hit = bus_req.addr == `LINK_REG;

   ////////////////////////////////////////////////////////////////////////
   // Clock blocks and link enable

   cb_cfg_type              cb_cfg_reg [`NUM_CB];
   logic                    link_en_reg;
   wire [`NUM_CB-1:0]       cb_tick;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         link_en_reg <= 1'b0;
      end else if (bus_req.wr && link_hit) begin
         link_en_reg <= bus_req.wdata[0];
      end
   end

   genvar c;
   generate
      for (c = 0; c < `NUM_CB; c++) begin : g_cb
         cb_cfg_type cfg_eff;

         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               cb_cfg_reg[c] <= cb_cfg_type'(`CB_RESET);
            end else if (bus_req.wr && cb_hit && cb_idx == 3'(c)) begin
               cb_cfg_reg[c] <= cb_cfg_type'(bus_req.wdata[`CB_CFG_W-1:0]);
            end
         end

         // Block 0 is always the undivided reference
         assign cfg_eff = (c == 0) ? cb_cfg_type'(`CB_RESET) : cb_cfg_reg[c];

         clock_block u_cb (
            .sys_clk   (sys_clk),
            .resetn    (resetn),
            .cfg       (cfg_eff),
            .pin_level (pin_sync_reg[PORT_BASE[0]]),
            .tick      (cb_tick[c]),
            .clk_level ()
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Ports

   logic [31:0]          port_rd   [NUM_PORTS];
   logic [31:0]          port_val  [NUM_PORTS];
   logic [31:0]          port_mask [NUM_PORTS];
   logic [NUM_PORTS-1:0] port_en;
   logic [NUM_PORTS-1:0] port_drv;
   logic [NUM_PORTS-1:0] port_od;

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         localparam int W      = PORT_WIDTH[p];
         localparam int B      = PORT_BASE[p];
         localparam int SLICES = 32 / W;
         localparam logic [63:0] ONES = (64'h1 << W) - 64'h1;

         port_ctrl_type  ctrl_reg;
         logic [31:0]    cond_reg;
         logic [15:0]    time_reg;
         logic [15:0]    count_reg;
         logic [15:0]    stamp_reg;
         logic [31:0]    xfer_reg;
         logic           xfer_full_reg;
         logic [31:0]    shift_reg;
         logic [5:0]     slice_reg;
         port_state_type state_reg;
         logic [W-1:0]   out_val_reg;
         logic           strobe_reg;
         logic           strobe_dly_reg;
         logic           event_reg;

         wire            wr_hit;
         wire            rd_hit;
         wire            tick;
         wire [W-1:0]    pins_now;
         wire            cond_ok;
         wire            time_ok;
         wire            start_in;
         wire            start_out;
         wire            strobe_ok;
         wire            last_slice;
         wire [31+W:0]   in_wide;
         wire [31:0]     in_word;

         assign wr_hit = bus_req.wr && port_hit && win_sel == 3'(p);
         assign rd_hit = bus_req.rd && port_hit && win_sel == 3'(p);

         // Pace every action by the selected clock block
         assign tick = ctrl_reg.enable &&
                       (ctrl_reg.cb_sel < 3'(`NUM_CB)) &&
                       cb_tick[ctrl_reg.cb_sel];

         assign pins_now = pin_sync_reg[B +: W];
         assign cond_ok  = (ctrl_reg.cond == COND_NONE) ||
                           ((ctrl_reg.cond == COND_EQ) &&
                            (pins_now == cond_reg[W-1:0])) ||
                           ((ctrl_reg.cond == COND_NEQ) &&
                            (pins_now != cond_reg[W-1:0]));
         assign time_ok  = !ctrl_reg.timed || (count_reg == time_reg);
         assign strobe_ok = !ctrl_reg.strobe_en || strobe_sync_reg[p];

         assign start_out = tick && ctrl_reg.dir_out && xfer_full_reg &&
                            time_ok && state_reg == ST_IDLE;
         assign start_in  = tick && !ctrl_reg.dir_out && cond_ok &&
                            time_ok && state_reg == ST_IDLE;
         assign last_slice = slice_reg == 6'h01;

         // Deserialiser shifts new slices in from the top
         assign in_wide = {pins_now, shift_reg} >> W;
         assign in_word = in_wide[31:0];

         // Configuration registers
         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               ctrl_reg <= port_ctrl_type'(`CTRL_RESET);
               cond_reg <= 32'h0000_0000;
               time_reg <= 16'h0000;
            end else if (wr_hit) begin
               if (reg_sel == `REG_CTRL) begin
                  ctrl_reg <= port_ctrl_type'(bus_req.wdata[`CTRL_W-1:0]);
               end
               if (reg_sel == `REG_COND) begin
                  cond_reg <= bus_req.wdata;
               end
               if (reg_sel == `REG_TIME) begin
                  time_reg <= bus_req.wdata[15:0];
               end
            end
         end

         // Free-running port counter
         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               count_reg <= `COUNT_RESET;
            end else if (tick) begin
               count_reg <= 16'(count_reg + 16'h0001);
            end
         end

         // Transfer register, serialiser and timestamp
         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               xfer_reg      <= 32'h0000_0000;
               xfer_full_reg <= 1'b0;
               shift_reg     <= 32'h0000_0000;
               slice_reg     <= 6'h00;
               state_reg     <= ST_IDLE;
               stamp_reg     <= 16'h0000;
               out_val_reg   <= '0;
               strobe_reg    <= 1'b0;
               strobe_dly_reg <= 1'b0;
               event_reg     <= 1'b0;
            end else begin
               event_reg <= 1'b0;
               // Strobe delayed one cycle so it lines up with the pin register
               strobe_dly_reg <= strobe_reg;
               if (tick) begin
                  strobe_reg <= 1'b0;
               end
               case (state_reg)
                  ST_IDLE: begin
                     if (start_out) begin
                        shift_reg <= xfer_reg;
                        slice_reg <= 6'(SLICES);
                        stamp_reg <= count_reg;
                        state_reg <= ST_SHIFT;
                        event_reg <= ctrl_reg.timed;
                     end else if (start_in) begin
                        slice_reg <= 6'(SLICES);
                        state_reg <= ST_SHIFT;
                        event_reg <= ctrl_reg.timed ||
                                     (ctrl_reg.cond != COND_NONE);
                     end
                  end
                  ST_SHIFT: begin
                     if (tick && ctrl_reg.dir_out) begin
                        out_val_reg <= shift_reg[W-1:0];
                        shift_reg   <= shift_reg >> W;
                        strobe_reg  <= 1'b1;
                        slice_reg   <= 6'(slice_reg - 6'h01);
                        if (last_slice) begin
                           state_reg <= ST_IDLE;
                        end
                     end else if (tick && strobe_ok) begin
                        shift_reg <= in_word;
                        slice_reg <= 6'(slice_reg - 6'h01);
                        if (last_slice) begin
                           xfer_reg  <= in_word;
                           stamp_reg <= count_reg;
                           state_reg <= ST_IDLE;
                        end
                     end
                  end
                  default: begin
                     state_reg <= ST_IDLE;
                  end
               endcase
               // New control word abandons a transfer in flight
               if (wr_hit && reg_sel == `REG_CTRL) begin
                  state_reg <= ST_IDLE;
               end
               // Data write loads the transfer register for output
               if (wr_hit && reg_sel == `REG_DATA && ctrl_reg.dir_out) begin
                  xfer_reg <= bus_req.wdata;
               end
               // Flag: set wins over clear in both directions
               if (wr_hit && reg_sel == `REG_DATA && ctrl_reg.dir_out) begin
                  xfer_full_reg <= 1'b1;
               end else if (state_reg == ST_SHIFT && tick &&
                            !ctrl_reg.dir_out && strobe_ok && last_slice) begin
                  xfer_full_reg <= 1'b1;
               end else if (start_out) begin
                  xfer_full_reg <= 1'b0;
               end else if (rd_hit && reg_sel == `REG_DATA &&
                            !ctrl_reg.dir_out) begin
                  xfer_full_reg <= 1'b0;
               end
            end
         end

         // Read view of this port
         assign port_rd[p] =
            (reg_sel == `REG_CTRL)   ? 32'(ctrl_reg) :
            (reg_sel == `REG_DATA)   ? xfer_reg :
            (reg_sel == `REG_COND)   ? cond_reg :
            (reg_sel == `REG_TIME)   ? {16'h0000, time_reg} :
            (reg_sel == `REG_COUNT)  ? {16'h0000, count_reg} :
            (reg_sel == `REG_STAMP)  ? {16'h0000, stamp_reg} :
            (reg_sel == `REG_STATUS) ? {30'h0, state_reg == ST_SHIFT,
                                        xfer_full_reg} :
            32'h0000_0000;

         // Pin-side view, placed at the port's base pin
         assign port_val[p]  = 32'({32'h0, out_val_reg} << B);
         assign port_mask[p] = 32'(ONES << B);
         assign port_en[p]   = ctrl_reg.enable;
         assign port_drv[p]  = ctrl_reg.enable && ctrl_reg.dir_out;
         assign port_od[p]   = ctrl_reg.open_drain;
         assign output_qualify_strobe[p] = strobe_dly_reg;
         assign ready_event[p]           = event_reg;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Pin ownership and drivers

   logic [`PIN_COUNT-1:0] pin_out_reg;
   logic [`PIN_COUNT-1:0] pin_oe_reg;
   logic [`PIN_COUNT-1:0] pin_out_next;
   logic [`PIN_COUNT-1:0] pin_oe_next;

   genvar i;
   generate
      for (i = 0; i < `PIN_COUNT; i++) begin : g_pin
         wire link_pin;

         assign link_pin = link_en_reg && (i >= LINK_BASE) &&
                           (i < LINK_BASE + LINK_WIDTH);

         // Ports are listed narrowest first, so the first owner wins
         always_comb begin
            logic found;
            found           = 1'b0;
            pin_out_next[i] = 1'b0;
            pin_oe_next[i]  = 1'b0;
            for (int q = 0; q < NUM_PORTS; q++) begin
               if (!found && port_en[q] && port_mask[q][i]) begin
                  found = 1'b1;
                  if (port_drv[q]) begin
                     if (port_od[q]) begin
                        pin_out_next[i] = 1'b0;
                        pin_oe_next[i]  = ~port_val[q][i];
                     end else begin
                        pin_out_next[i] = port_val[q][i];
                        pin_oe_next[i]  = 1'b1;
                     end
                  end
               end
            end
            if (link_pin) begin
               pin_out_next[i] = 1'b0;
               pin_oe_next[i]  = 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pin_out_reg <= '0;
         pin_oe_reg  <= '0;
      end else begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg  <= pin_oe_next;
      end
   end

   assign pin_out = pin_out_reg;
   assign pin_oe  = pin_oe_reg;

   ////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe

   logic [31:0] rd_data_reg;
   wire  [31:0] rd_mux;

   assign rd_mux = port_hit ? port_rd[win_sel] :
                   cb_hit   ? {23'h0, cb_cfg_reg[cb_idx]} :
                   link_hit ? {31'h0, link_en_reg} :
                   32'h0000_0000;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rd_data_reg <= 32'h0000_0000;
      end else begin
         rd_data_reg <= bus_req.rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign rd_data = rd_data_reg;

endmodule : timed_io_ports

// ### core/tio_params.svh
// Purpose: Offsets, reset values and timing counts of the timed I/O ports
// Assumes: Included by bare name after the types package
// Notes:   Byte offsets on the plain register port
`ifndef TIO_PARAMS_SVH
`define TIO_PARAMS_SVH

`define ADDR_W        8
`define NUM_CB        6
`define PIN_COUNT     32

// Per-port register offsets inside a 32-byte window
`define PORT_STRIDE   8'h20
`define REG_CTRL      5'h00
`define REG_DATA      5'h04
`define REG_COND      5'h08
`define REG_TIME      5'h0c
`define REG_COUNT     5'h10
`define REG_STAMP     5'h14
`define REG_STATUS    5'h18

// Global registers
`define CB_BASE       8'ha0
`define CB_WIN_MASK   8'he0
`define LINK_REG      8'hc0

// Reset values
`define CTRL_RESET    10'h000
`define CB_RESET      9'h000
`define COUNT_RESET   16'h0000

// Widths of the control word and the clock block configuration
`define CTRL_W        10
`define CB_CFG_W      9

// Clocking figures
`define REF_CLK_MHZ   100
`define SYS_CLK_MHZ   20

`endif

// ### core/tio_pkg.sv
// Purpose: Types shared by the timed I/O port design
// Assumes: Nothing
// Notes:   Field layout matches the widths in tio_params.svh
package tio_pkg;

   typedef enum logic [1:0] {
      COND_NONE,
      COND_EQ,
      COND_NEQ
   } cond_mode_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SHIFT
   } port_state_type;

   // Bit 0 is enable
   typedef struct packed {
      logic [2:0]    cb_sel;
      logic          strobe_en;
      logic          timed;
      cond_mode_type cond;
      logic          open_drain;
      logic          dir_out;
      logic          enable;
   } port_ctrl_type;

   typedef struct packed {
      logic       use_pin;
      logic [7:0] div;
   } cb_cfg_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_type;

endpackage : tio_pkg

// ### core/clock_block.sv
// Purpose: One programmable clock block producing a tick every div+1 source edges
// Assumes: pin_level is already synchronised to sys_clk
// Notes:   Divide of zero passes every source edge
`timescale 1ns/1ps
module clock_block (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // Configuration
   input  wire tio_pkg::cb_cfg_type cfg,
   input  wire logic              pin_level,
   // Tick out
   output logic                   tick,
   output logic                   clk_level
);
   import tio_pkg::*;

   logic       pin_prev_reg;
   logic [7:0] div_cnt_reg;
   logic [7:0] div_cnt_next;
   logic       tick_reg;
   logic       level_reg;
   wire        src_edge;
   wire        div_done;

   // Reference source ticks every cycle, pin source on rising edges
   assign src_edge = cfg.use_pin ? (pin_level & ~pin_prev_reg) : 1'b1;
   assign div_done = src_edge && (div_cnt_reg >= cfg.div);
   assign div_cnt_next = div_done ? 8'h00 :
                         src_edge ? 8'(div_cnt_reg + 8'h01) : div_cnt_reg;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pin_prev_reg <= 1'b0;
         div_cnt_reg  <= 8'h00;
         tick_reg     <= 1'b0;
         level_reg    <= 1'b0;
      end else begin
         pin_prev_reg <= pin_level;
         div_cnt_reg  <= div_cnt_next;
         tick_reg     <= div_done;
         level_reg    <= div_done ? ~level_reg : level_reg;
      end
   end

   assign tick      = tick_reg;
   assign clk_level = level_reg;

endmodule : clock_block

// ### sim/pin_partner.sv
// Purpose: External hardware on the device pins
// Assumes: Bench sets what the far side drives and where pull-ups sit
// Notes:   Undriven pins settle to their resistor level
`timescale 1ns/1ps
`include "tio_params.svh"
module pin_partner (
   // Device side
   input  wire logic [`PIN_COUNT-1:0] pin_out,
   input  wire logic [`PIN_COUNT-1:0] pin_oe,
   output logic      [`PIN_COUNT-1:0] pin_in,
   // Bench control
   input  wire logic [`PIN_COUNT-1:0] ext_val,
   input  wire logic [`PIN_COUNT-1:0] ext_oe,
   input  wire logic [`PIN_COUNT-1:0] pull_up
);
   // Device first, then far side, then the resistor
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                 | (~pin_oe & ~ext_oe & pull_up);
endmodule : pin_partner

// ### sim/timed_io_ports_checker.sv
// Purpose: Port-level checks of the timed I/O ports
// Assumes: Register map as in tio_params.svh
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`include "tio_params.svh"
module timed_io_ports_checker #(
   parameter int NUM_PORTS = 5
) (
   input wire logic                 sys_clk,
   input wire logic                 resetn,
   input wire tio_pkg::bus_req_type bus_req,
   input wire logic [31:0]          rd_data,
   input wire logic [`PIN_COUNT-1:0] pin_in,
   input wire logic [`PIN_COUNT-1:0] pin_out,
   input wire logic [`PIN_COUNT-1:0] pin_oe,
   input wire logic [NUM_PORTS-1:0] strobe_in,
   input wire logic [NUM_PORTS-1:0] output_qualify_strobe,
   input wire logic [NUM_PORTS-1:0] ready_event
);
   import tio_pkg::*;
   default clocking chk_clk @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic link_reg;
   logic od1_reg;
   logic od_seen_reg;
   wire  wr_link  = bus_req.wr && bus_req.addr == `LINK_REG;
   wire  wr_ctrl  = bus_req.wr && bus_req.addr < `CB_BASE
                    && bus_req.addr[4:0] == `REG_CTRL;
   wire  wr_ctrl1 = wr_ctrl && bus_req.addr == 8'h20;
   wire  rd_port  = bus_req.rd && bus_req.addr < `CB_BASE;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         link_reg    <= 1'b0;
         od1_reg     <= 1'b0;
         od_seen_reg <= 1'b0;
      end else begin
         if (wr_link) link_reg <= bus_req.wdata[0];
         if (wr_ctrl1) od1_reg <= &bus_req.wdata[2:0];
         if (wr_ctrl && bus_req.wdata[2]) od_seen_reg <= 1'b1;
      end
   end
   //////////////////////////////////////////////////////////////////////
   rd_idle_a:
   assert property (!$past(bus_req.rd) |-> rd_data == 32'h0)
      else $error("read data not zero outside a read");
   unmap_rd_a:
   assert property (bus_req.rd && bus_req.addr >= 8'hc4 |=> rd_data == 32'h0)
      else $error("unmapped read not zero");
   count_width_a:
   assert property (rd_port && bus_req.addr[4:0] == `REG_COUNT
                    |=> rd_data[31:16] == 16'h0)
      else $error("counter wider than 16 bits");
   stamp_width_a:
   assert property (rd_port && bus_req.addr[4:0] == `REG_STAMP
                    |=> rd_data[31:16] == 16'h0)
      else $error("stamp wider than 16 bits");
   link_off_a:
   assert property (link_reg && $past(link_reg, 2) |-> pin_oe[11:8] == 4'h0)
      else $error("link pin driven by a port");
   od_drive_a:
   assert property (od1_reg && $past(od1_reg, 2)
                    |-> (pin_oe[7:4] & pin_out[7:4]) == 4'h0)
      else $error("open-drain pin driven high");
   dir_same_a:
   assert property (!od_seen_reg
                    |-> pin_oe[7:4] == 4'h0 || pin_oe[7:4] == 4'hf)
      else $error("mixed direction inside a port");
   reset_idle_a:
   assert property ($rose(resetn) |-> pin_oe == '0 && ready_event == '0
                    && output_qualify_strobe == '0)
      else $error("outputs active after reset");
   cover property (ready_event[NUM_PORTS-1]);
   cover property (output_qualify_strobe[0]);
   cover property (link_reg && pin_oe[31]);
endmodule : timed_io_ports_checker

// ### sim/tb_timed_io_ports.sv
// Purpose: Self-checking bench of the timed I/O ports
// Assumes: Default top parameters, block 0 ticks every cycle
// Notes:   Reads and pin slices are checked from queues by a monitor
`timescale 1ns/1ps
`include "tio_params.svh"
module tb_timed_io_ports;
   import tio_pkg::*;
   typedef struct packed {
      logic [31:0] mask;
      logic [31:0] val;
      logic        od;
   } note_type;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   bus_req_type bus_req = '0;
   logic [31:0] rd_data, pin_in, pin_out, pin_oe, last_rd, w, c;
   logic [31:0] ext_val = '0, ext_oe = '0, pull_up = '0;
   logic [4:0]  strobe_in = '0, oq_strobe, ready_event;
   logic [32:0] rdq[$];
   note_type    pq[5][$];
   logic [15:0] t;
   logic        rd_seen = 1'b0;
   int          error_cnt = 0, n_checks = 0, seed = 40, rdys = 0;

   always #25 sys_clk = ~sys_clk;
   timed_io_ports dut (.sys_clk(sys_clk), .resetn(resetn),
      .bus_req(bus_req), .rd_data(rd_data), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .strobe_in(strobe_in),
      .output_qualify_strobe(oq_strobe), .ready_event(ready_event));
   pin_partner far (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
      .ext_val(ext_val), .ext_oe(ext_oe), .pull_up(pull_up));
   //////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req <= '0;
      @(posedge sys_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic k);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      rdq.push_back({k, e});
      @(posedge sys_clk);
      bus_req <= '0;
      @(posedge sys_clk);
   endtask : rd
   task automatic drain();
      for (int k = 0; k < 200; k++)
         if (pq[0].size() + pq[1].size() + pq[4].size() != 0) @(posedge sys_clk);
      cmp(pq[0].size() + pq[1].size() + pq[4].size() == 0, "slices missing");
   endtask : drain
   task automatic end_sim();
      if (error_cnt == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   //////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk) rd_seen <= bus_req.rd;
   // Monitor: read data and driven slices against the oldest note
   always @(negedge sys_clk) begin
      logic [32:0] e;
      note_type    n;
      if (ready_event[4] === 1'b1) rdys++;
      if (rd_seen) begin
         e = rdq.pop_front();
         last_rd = rd_data;
         if (e[32]) cmp(rd_data === e[31:0], "read data");
      end
      for (int p = 0; p < 5; p++)
         if (oq_strobe[p] === 1'b1) begin
            if (pq[p].size() == 0) cmp(1'b0, "unexpected strobe");
            else begin
               n = pq[p].pop_front();
               if (n.od) cmp((pin_oe & n.mask) === (~n.val & n.mask), "drain");
               else cmp((pin_out & n.mask) === n.val, "pin slice");
            end
         end
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      for (int p = 0; p < 5; p++) rd(8'(p * 32), 32'h0, 1'b1);
      rd(8'he4, 32'h0, 1'b1);
      wr(8'h40, 32'h181);
      rd(8'h40, 32'h181, 1'b1);
      wr(8'h40, 32'h001);
      rd(8'h50, 32'h0, 1'b0);
      c = last_rd;
      rd(8'h50, c + 32'd2, 1'b1);
      wr(8'h40, 32'h0);
      // Single-pin port shifts a whole word out
      w = $random(seed);
      wr(8'h00, 32'h43);
      for (int i = 0; i < 32; i++) pq[0].push_back('{32'h1, {31'h0, w[i]}, 1'b0});
      wr(8'h04, w);
      drain();
      wr(8'h00, 32'h0);
      // Timed word on the widest port
      w = $random(seed);
      wr(8'h80, 32'h63);
      rd(8'h90, 32'h0, 1'b0);
      t = last_rd[15:0] + 16'd40;
      wr(8'h8c, {16'h0, t});
      pq[4].push_back('{32'hffffffff, w, 1'b0});
      rdys = 0;
      wr(8'h84, w);
      drain();
      cmp(rdys == 1, "ready event");
      rd(8'h94, {16'h0, t}, 1'b1);
      wr(8'h80, 32'h0);
      // Block 1 paced by the pin, divided by two
      wr(`CB_BASE + 8'h04, 32'h101);
      wr(8'h60, 32'h081);
      rd(8'h70, 32'h0, 1'b0);
      c = last_rd;
      ext_oe[0] <= 1'b1;
      repeat (8) begin
         ext_val[0] <= 1'b1;
         repeat (2) @(posedge sys_clk);
         ext_val[0] <= 1'b0;
         repeat (2) @(posedge sys_clk);
      end
      repeat (6) @(posedge sys_clk);
      rd(8'h70, c + 32'd4, 1'b1);
      wr(8'h60, 32'h0);
      // Strobed word into the widest port
      w = $random(seed);
      wr(8'h80, 32'h041);
      ext_oe  <= '1;
      ext_val <= w;
      strobe_in[4] <= 1'b1;
      @(posedge sys_clk);
      strobe_in[4] <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd(8'h98, 32'h3, 1'b1);
      rd(8'h84, w, 1'b1);
      wr(8'h80, 32'h0);
      ext_oe <= '0;
      // Link, open-drain narrow port and the wide port together
      w = $random(seed);
      pull_up <= 32'hf0;
      wr(`LINK_REG, 32'h1);
      wr(8'h20, 32'h47);
      wr(8'h80, 32'h43);
      for (int i = 0; i < 8; i++) pq[1].push_back('{32'hf0, {24'h0, w[4*i +: 4], 4'h0}, 1'b1});
      pq[4].push_back('{32'hfffff00f, w & 32'hfffff00f, 1'b0});
      wr(8'h24, w);
      wr(8'h84, w);
      drain();
      end_sim();
   end
   initial begin
      repeat (3000) @(posedge sys_clk);
      error_cnt++;
      end_sim();
   end
endmodule : tb_timed_io_ports

bind timed_io_ports timed_io_ports_checker #(.NUM_PORTS(NUM_PORTS)) chk (
   .sys_clk(sys_clk), .resetn(resetn), .bus_req(bus_req),
   .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .strobe_in(strobe_in), .output_qualify_strobe(output_qualify_strobe),
   .ready_event(ready_event));
